//--- cmac_pkg.sv
// Purpose: Shared constants and types for the core memory access controller
// Assumes: 40 MHz clock, 10 MHz memory time base derived by a divider
// Notes:   Word is 24 data bits plus one parity bit
package cmac_pkg;

  localparam int unsigned DATA_W      = 24;
  localparam int unsigned WORD_W      = 25;
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned N_REQ       = 4;
  localparam int unsigned MOD_SEL_BIT = 14;
  localparam int unsigned BLK_W       = 12;
  localparam int unsigned MOD_BLK_W   = 14;
  localparam int unsigned BIT_LINE_W  = 4;
  localparam int unsigned WORD_LINE_W = 8;
  localparam int unsigned CLK_HZ      = 40000000;
  localparam int unsigned TICK_HZ     = 10000000;
  localparam int unsigned TICK_DIV    = CLK_HZ / TICK_HZ;
  localparam logic [3:0]  TC_INIT_OFF = 4'h2;
  localparam logic [3:0]  TC_READY    = 4'h8;
  localparam logic [3:0]  TC_DONE     = 4'hf;
  localparam logic [3:0]  TC_STROBE   = 4'h6;
  localparam logic [2:0]  PLANES_DEF  = 3'h4;
  localparam logic [1:0]  MODS_DEF    = 2'h2;

  typedef enum logic [1:0] {
    CMAC_IDLE  = 2'b00,
    CMAC_CYCLE = 2'b01,
    CMAC_DONE  = 2'b10
  } cmac_state_e;

  typedef struct packed {
    logic              req;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmac_req_s;

  typedef struct packed {
    logic [1:0]             plane;
    logic [WORD_LINE_W-1:0] word_line;
    logic [BIT_LINE_W-1:0]  bit_line;
  } cmac_sel_s;

endpackage : cmac_pkg

//--- cmac_arb.sv
// Purpose: Fixed priority pick among latched requests
// Assumes: Bit 0 is channel 1, bit 3 the arithmetic unit
// Notes:   Purely combinational
`timescale 1ns/1ps
module cmac_arb #(
  parameter int unsigned N = 4
) (
  input  wire logic [N-1:0] pend_i,
  output logic      [N-1:0] win_o
);
  logic [N-1:0] higher;
  assign higher[0] = 1'b0;
  for (genvar g = 1; g < N; g++) begin : g_pri
    assign higher[g] = higher[g-1] | pend_i[g-1];
  end
  assign win_o = pend_i & ~higher;
endmodule : cmac_arb

//--- cmac_store.sv
// Purpose: Core storage model of two modules of up to four planes each
// Assumes: Write port and read port synchronous to the clock
// Notes:   Destructive read is restored by the controller write back
`timescale 1ns/1ps
module cmac_store #(
  parameter int unsigned DEPTH = 32768
) (
  input  wire logic                      clk_i,
  input  wire logic                      ce_i,
  input  wire logic                      we_i,
  input  wire logic [$clog2(DEPTH)-1:0]  addr_i,
  input  wire logic [cmac_pkg::WORD_W-1:0] wdata_i,
  output logic      [cmac_pkg::WORD_W-1:0] rdata_o
);
  logic [cmac_pkg::WORD_W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule : cmac_store

//--- cmac_ctrl.sv
// Overview of operation
// - Four requesters: channels one to three plus the arithmetic unit.
// - Exactly one requester is granted, grant goes to it alone.
// - Fixed priority channel 1, 2, 3, then arithmetic unit lowest.
// - Operation type and initiate are sent to the memory module.
// - Write data is multiplexed, odd parity added, loaded into data register.
// - Write cycle clears the word, drops sensed data, sets the one bits.
// - Read cycle strobes the word into the data register and restores it.
// - Read data goes to the requester with a data-ready pulse.
// - Arithmetic unit gets a release at cycle end for read and write.
// - Read words are checked for odd parity, errors flagged.
// - Parity error drives indicator and branch test, may stop unit accesses.
// - Up to 32K words in one or two modules of 16K.
// - Address bit 14 picks lower or upper module to initiate when over 16K words are installed.
// - Only address bits for the installed size are used, others alias.
// - Empty 4K block reads zero without parity error, writes ignored.
// - Each stored word is 25 bits with parity.
// - A 4K plane decodes as 16 bit lines by 256 word lines.
// - Module size is 4K to 16K in 4K steps, one to four planes.
// - Requests latch when idle or at the last clock of a cycle.
// - Cycle counter runs at 10 MHz from grant, initiate drops at two.
// - Data-ready goes out when the counter reaches octal ten.
// - Cycle ends at octal seventeen, next request served, release sent.
//
// Purpose: Memory access control with priority, timing, parity and wrap
// Assumes: Requesters hold their inputs stable until the cycle ends
// Notes:   Index 0 is channel 1, index 3 the arithmetic unit
`timescale 1ns/1ps
module cmac_ctrl #(
  parameter logic [2:0] PLANES  = cmac_pkg::PLANES_DEF,
  parameter logic [1:0] MODULES = cmac_pkg::MODS_DEF
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  input  wire logic                                  ce_i,
  input  wire cmac_pkg::cmac_req_s [cmac_pkg::N_REQ-1:0] req_i,
  input  wire logic                                  stop_on_parity_i,
  input  wire logic                                  temp_alarm_i,
  input  wire logic                                  parity_clear_i,
  output logic      [cmac_pkg::N_REQ-1:0]            grant_o,
  output logic      [cmac_pkg::N_REQ-1:0]            data_ready_o,
  output logic      [cmac_pkg::DATA_W-1:0]           rdata_o,
  output logic                                       au_release_o,
  output logic                                       init_lower_o,
  output logic                                       init_upper_o,
  output logic                                       op_write_o,
  output logic                                       op_read_o,
  output cmac_pkg::cmac_sel_s                        sel_o,
  output logic                                       parity_err_o,
  output logic                                       parity_ok_test_o
);
  localparam int unsigned AU = cmac_pkg::N_REQ - 1;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic odd_par(input logic [cmac_pkg::DATA_W-1:0] d);
    odd_par = ~(^d);
  endfunction : odd_par

  ////////////////////////////////////////////////////////////////////////////
  // State
  cmac_pkg::cmac_state_e              state_reg, state_next;
  logic [cmac_pkg::N_REQ-1:0]         pend_reg, pend_next;
  logic [cmac_pkg::N_REQ-1:0]         owner_reg;
  logic [3:0]                         tc_reg;
  logic [1:0]                         div_reg;
  logic                               write_reg;
  logic [cmac_pkg::ADDR_W-1:0]        addr_reg;
  logic [cmac_pkg::WORD_W-1:0]        dreg_reg;
  logic                               empty_reg;
  logic                               perr_reg;
  logic                               sensed_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Request latch and arbitration
  logic [cmac_pkg::N_REQ-1:0] req_vec;
  logic [cmac_pkg::N_REQ-1:0] win;
  logic                       au_block;
  logic                       last_tick;
  logic                       tick;
  logic                       may_latch;

  assign au_block = perr_reg & stop_on_parity_i;
  for (genvar r = 0; r < cmac_pkg::N_REQ; r++) begin : g_req
    if (r == AU) begin : g_au
      assign req_vec[r] = req_i[r].req & ~au_block;
    end else begin : g_ch
      assign req_vec[r] = req_i[r].req;
    end
  end

  assign tick      = (div_reg == 2'(cmac_pkg::TICK_DIV - 1));
  assign last_tick = (state_reg == cmac_pkg::CMAC_CYCLE) && tick
                     && (tc_reg == cmac_pkg::TC_DONE);
  assign may_latch = (state_reg == cmac_pkg::CMAC_IDLE) || last_tick;
  assign pend_next = may_latch ? req_vec : (pend_reg & req_vec);

  cmac_arb #(
    .N (cmac_pkg::N_REQ)
  ) u_arb (
    .pend_i (pend_reg),
    .win_o  (win)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Winner multiplex and address shaping
  cmac_pkg::cmac_req_s win_req;
  always_comb begin
    win_req = '0;
    for (int i = 0; i < cmac_pkg::N_REQ; i++) begin
      if (win[i]) begin
        win_req = req_i[i];
      end
    end
  end

  // Installed blocks: per module PLANES, modules MODULES
  logic [4:0]  total_blk;
  logic [2:0]  blk;
  logic [2:0]  blk_in_mod;
  logic        mod_sel;
  logic [cmac_pkg::ADDR_W-1:0] eff_addr;
  logic [cmac_pkg::ADDR_W-1:0] amask;
  logic        is_empty;

  assign total_blk = 5'(PLANES) * 5'(MODULES);
  // Mask wide enough for installed size, rounded up to a power of two
  assign amask = (total_blk > 5'h4) ? 15'h7fff :
                 (total_blk > 5'h2) ? 15'h3fff :
                 (total_blk > 5'h1) ? 15'h1fff : 15'h0fff;
  assign eff_addr   = win_req.addr & amask;
  assign mod_sel    = eff_addr[cmac_pkg::MOD_SEL_BIT];
  assign blk        = eff_addr[cmac_pkg::ADDR_W-1:cmac_pkg::BLK_W];
  assign blk_in_mod = {1'b0, blk[1:0]};
  assign is_empty   = (blk_in_mod >= PLANES) ||
                      (2'(mod_sel) >= MODULES);

  ////////////////////////////////////////////////////////////////////////////
  // Cycle control
  logic start;
  assign start = (state_reg == cmac_pkg::CMAC_IDLE) && (pend_reg != '0)
                 && !temp_alarm_i;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cmac_pkg::CMAC_IDLE: begin
        if (start) begin
          state_next = cmac_pkg::CMAC_CYCLE;
        end
      end
      cmac_pkg::CMAC_CYCLE: begin
        if (last_tick) begin
          state_next = cmac_pkg::CMAC_DONE;
        end
      end
      cmac_pkg::CMAC_DONE: begin
        state_next = cmac_pkg::CMAC_IDLE;
      end
      default: begin
        state_next = cmac_pkg::CMAC_IDLE;
      end
    endcase
  end

  logic count_en;
  assign count_en = (state_reg == cmac_pkg::CMAC_CYCLE) && !temp_alarm_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= cmac_pkg::CMAC_IDLE;
      pend_reg  <= '0;
      div_reg   <= 2'h0;
      tc_reg    <= 4'h0;
    end else if (ce_i) begin
      state_reg <= state_next;
      pend_reg  <= pend_next;
      div_reg   <= (count_en && !tick) ? div_reg + 2'h1 : 2'h0;
      if (start) begin
        tc_reg <= 4'h0;
      end else if (count_en && tick) begin
        tc_reg <= tc_reg + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Captured cycle parameters and data register
  logic [cmac_pkg::WORD_W-1:0] sense_word;
  logic                        strobe;
  logic                        restore_we;
  logic [cmac_pkg::WORD_W-1:0] wr_word;

  assign wr_word = {odd_par(win_req.data), win_req.data};
  assign strobe  = count_en && tick && (tc_reg == cmac_pkg::TC_STROBE)
                   && !sensed_reg;
  // Clear then set: store writes the data register word, restore on read
  assign restore_we = count_en && tick && (tc_reg == cmac_pkg::TC_READY)
                      && !empty_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      owner_reg  <= '0;
      write_reg  <= 1'b0;
      addr_reg   <= '0;
      dreg_reg   <= '0;
      empty_reg  <= 1'b0;
      sensed_reg <= 1'b0;
    end else if (ce_i) begin
      if (start) begin
        owner_reg  <= win;
        write_reg  <= win_req.write;
        addr_reg   <= eff_addr;
        empty_reg  <= is_empty;
        sensed_reg <= 1'b0;
        dreg_reg   <= win_req.write ? wr_word : '0;
      end else if (strobe) begin
        sensed_reg <= 1'b1;
        if (!write_reg) begin
          dreg_reg <= empty_reg ? '0 : sense_word;
        end
      end
    end
  end

  cmac_store #(
    .DEPTH (32768)
  ) u_store (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (restore_we),
    .addr_i  (addr_reg),
    .wdata_i (dreg_reg),
    .rdata_o (sense_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic rd_par_bad;
  assign rd_par_bad = !write_reg && !empty_reg &&
                      (odd_par(sense_word[cmac_pkg::DATA_W-1:0]) !=
                       sense_word[cmac_pkg::WORD_W-1]);

  logic ready_evt;
  assign ready_evt = count_en && tick && (tc_reg == cmac_pkg::TC_READY - 4'h1);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      grant_o          <= '0;
      data_ready_o     <= '0;
      rdata_o          <= '0;
      au_release_o     <= 1'b0;
      init_lower_o     <= 1'b0;
      init_upper_o     <= 1'b0;
      op_write_o       <= 1'b0;
      op_read_o        <= 1'b0;
      sel_o            <= '0;
      perr_reg         <= 1'b0;
      parity_err_o     <= 1'b0;
      parity_ok_test_o <= 1'b1;
    end else if (ce_i) begin
      if (start) begin
        grant_o      <= win;
        op_write_o   <= win_req.write;
        op_read_o    <= !win_req.write;
        init_lower_o <= !is_empty && !mod_sel;
        init_upper_o <= !is_empty && mod_sel;
        sel_o.plane     <= eff_addr[13:12];
        sel_o.word_line <= eff_addr[11:4];
        sel_o.bit_line  <= eff_addr[3:0];
      end else if (count_en && tick && (tc_reg == cmac_pkg::TC_INIT_OFF - 4'h1)) begin
        init_lower_o <= 1'b0;
        init_upper_o <= 1'b0;
      end else if (last_tick) begin
        grant_o    <= '0;
        op_write_o <= 1'b0;
        op_read_o  <= 1'b0;
      end
      data_ready_o <= ready_evt ? owner_reg : '0;
      if (ready_evt && !write_reg) begin
        rdata_o <= dreg_reg[cmac_pkg::DATA_W-1:0];
      end
      au_release_o <= last_tick && owner_reg[AU];
      if (strobe && rd_par_bad) begin
        perr_reg     <= 1'b1;
        parity_err_o <= 1'b1;
        parity_ok_test_o <= 1'b0;
      end else if (parity_clear_i) begin
        perr_reg     <= 1'b0;
        parity_err_o <= 1'b0;
        parity_ok_test_o <= 1'b1;
      end
    end
  end

endmodule : cmac_ctrl

//--- cmac_monitor.sv
// Purpose: Port checks on grant, timing, module select and parity flags
// Assumes: Windows allow for the phase of the 10 MHz tick
// Notes:   Helper counters time each cycle from grant
`timescale 1ns/1ps
module cmac_monitor (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire cmac_pkg::cmac_req_s [3:0] req_i,
  input wire logic [3:0]                grant_o,
  input wire logic [3:0]                data_ready_o,
  input wire logic                      au_release_o,
  input wire logic                      init_lower_o,
  input wire logic                      init_upper_o,
  input wire logic                      op_write_o,
  input wire logic                      op_read_o,
  input wire logic                      parity_err_o,
  input wire logic                      parity_ok_test_o
);
  logic [7:0]  gcnt_reg, lcnt_reg;
  logic [3:0]  lown_reg;
  logic [14:0] own_addr;
  logic        own_wr;
  wire         init_any = init_lower_o | init_upper_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  always_comb begin
    own_addr = 15'h0;
    own_wr = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (grant_o[i]) begin
        own_addr = req_i[i].addr;
        own_wr = req_i[i].write;
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gcnt_reg <= 8'h0;
      lcnt_reg <= 8'h0;
      lown_reg <= 4'h0;
    end else if (grant_o == 4'h0) begin
      gcnt_reg <= 8'h0;
    end else begin
      gcnt_reg <= gcnt_reg + 8'h1;
      lcnt_reg <= gcnt_reg;
      lown_reg <= grant_o;
    end
  end
  ////////////////////////////////////////////////////////////
  a_grant_one_hot: assert property ($onehot0(grant_o))
    else $error("grant not one hot");
  a_ready_owner: assert property (|data_ready_o |-> data_ready_o == grant_o)
    else $error("data ready not to owner");
  a_ready_time: assert property (|data_ready_o |-> gcnt_reg inside {[26:38]})
    else $error("data ready at wrong count");
  a_release_owner: assert property (au_release_o |-> lown_reg == 4'h8)
    else $error("release without arith owner");
  a_release_time: assert property (au_release_o |-> lcnt_reg inside {[52:72]})
    else $error("release at wrong count");
  a_init_module: assert property (init_any |-> !(init_lower_o && init_upper_o)
    && init_upper_o == own_addr[14] && grant_o != 4'h0)
    else $error("wrong module initiated");
  a_init_width: assert property ($rose(init_any) |-> init_any [*5] ##[1:5] !init_any)
    else $error("initiate width wrong");
  a_op_type: assert property ((|grant_o && (op_write_o || op_read_o))
    |-> op_write_o == own_wr && op_read_o == !own_wr)
    else $error("operation type wrong");
  a_parity_test: assert property (parity_ok_test_o == !parity_err_o)
    else $error("parity test flag wrong");
  c_ready_ch1: cover property (data_ready_o[0]);
  c_release: cover property (au_release_o);
  c_upper_write: cover property (init_upper_o && op_write_o);
endmodule : cmac_monitor

//--- cmac_req_model.sv
// Purpose: Four requesters presenting type, address and data
// Assumes: One outstanding request a channel
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/1ps
module cmac_req_model (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [3:0]           grant_i,
  input  wire logic [3:0]           data_ready_i,
  input  wire logic [23:0]          rdata_i,
  output cmac_pkg::cmac_req_s [3:0] req_o,
  output logic [3:0]                done_o
);
  cmac_pkg::cmac_req_s [3:0] out_reg;
  logic [3:0]  arm_reg, gnt_reg, fall;
  logic [23:0] rd_reg [4];
  int          wait_reg [4];
  assign fall = gnt_reg & ~grant_i;
  ////////////////////////////////////////////////////////////
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      req_o[i] = out_reg[i];
      req_o[i].req = out_reg[i].req & ~fall[i];
    end
  end
  task automatic issue(input int i, input logic w, input logic [14:0] a,
                       input logic [23:0] d, input int dl);
    arm_reg[i] <= 1'b1;
    wait_reg[i] <= dl;
    done_o[i] <= 1'b0;
    rd_reg[i] <= 'x;
    out_reg[i] <= {1'b0, w, a, d};
  endtask : issue
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_reg <= '0;
      arm_reg <= 4'h0;
      gnt_reg <= 4'h0;
      done_o <= 4'h0;
    end else begin
      gnt_reg <= grant_i;
      for (int i = 0; i < 4; i++) begin
        if (data_ready_i[i])
          rd_reg[i] <= rdata_i;
        if (arm_reg[i] && wait_reg[i] > 0)
          wait_reg[i] <= wait_reg[i] - 1;
        else if (arm_reg[i])
          out_reg[i].req <= 1'b1;
        if (out_reg[i].req && fall[i]) begin
          out_reg[i] <= {1'b0, ~out_reg[i][39:0]};
          arm_reg[i] <= 1'b0;
          done_o[i] <= 1'b1;
        end
      end
    end
  end
endmodule : cmac_req_model

//--- core_memory_access_control_bench.sv
// Purpose: Self checking bench for the memory access controller
// Assumes: Three planes in each of two modules, block three empty
// Notes:   Expected words come from a sparse storage model
`timescale 1ns/1ps
module core_memory_access_control_bench;
  logic clk_i, rst_i, ce_i, stop_on_parity_i, temp_alarm_i, parity_clear_i;
  cmac_pkg::cmac_req_s [3:0] req;
  cmac_pkg::cmac_sel_s       sel;
  logic [3:0]  grant, rdy, done;
  logic [23:0] rdata, d, exp_w [4], mem [int];
  logic        rel, il, iu, opw, opr, perr, pok;
  logic [15:0] seed;
  logic [14:0] a, tab [4] = '{15'h0123, 15'h4123, 15'h3123, 15'h7fff};
  int          errors, n_checks;
  cmac_ctrl #(.PLANES(3'h3), .MODULES(2'h2)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .req_i(req), .stop_on_parity_i(stop_on_parity_i), .temp_alarm_i(temp_alarm_i),
    .parity_clear_i(parity_clear_i), .grant_o(grant), .data_ready_o(rdy), .rdata_o(rdata),
    .au_release_o(rel), .init_lower_o(il), .init_upper_o(iu), .op_write_o(opw),
    .op_read_o(opr), .sel_o(sel), .parity_err_o(perr), .parity_ok_test_o(pok));
  cmac_req_model m (.clk_i(clk_i), .rst_i(rst_i), .grant_i(grant), .data_ready_i(rdy),
    .rdata_i(rdata), .req_o(req), .done_o(done));
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_done(input int i);
    int k;
    k = 0;
    while (done[i] !== 1'b1 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 400) begin
      errors++;
      $display("[FAIL] done of channel %0d expected 1 seen %b", i, done[i]);
      complete_run();
    end
  endtask : wait_done
  task automatic put(input int i, input logic w, input logic [14:0] ad, input logic [23:0] dd);
    exp_w[i] = (ad[13:12] == 2'h3 || !mem.exists(ad)) ? 24'h0 : mem[ad];
    if (w && ad[13:12] != 2'h3)
      mem[ad] = dd;
    m.issue(i, w, ad, dd, i % 3);
  endtask : put
  task automatic xfer(input int i, input logic w, input logic [14:0] ad, input logic [23:0] dd);
    put(i, w, ad, dd);
    @(posedge clk_i);
    wait_done(i);
    chk("sel", {10'h0, ad[13:0]}, {10'h0, sel});
    if (!w)
      chk("rdata", exp_w[i], m.rd_reg[i]);
    chk("parity_err", 24'h0, {23'h0, perr});
  endtask : xfer
  ////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    ce_i = 1'b1;
    rst_i = 1'b1;
    stop_on_parity_i = 1'b0;
    temp_alarm_i = 1'b0;
    parity_clear_i = 1'b0;
    errors = 0;
    n_checks = 0;
    seed = 16'h002e;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("grant", 24'h0, {20'h0, grant});
    chk("parity_ok", 24'h1, {23'h0, pok});
    $display("test reset done");
    for (int n = 0; n < 12; n++) begin
      seed = lfsr(seed);
      a = seed[14:0];
      a[13] = a[13] & ~a[12];
      d = {seed[7:0], lfsr(seed)};
      xfer(n % 4, 1'b1, a, d);
      xfer(3 - n % 4, 1'b0, a, 24'h0);
    end
    $display("test random done");
    parity_clear_i <= 1'b1;
    for (int k = 0; k < 4; k++)
      xfer(k, 1'b1, tab[k], {9'h0a5, tab[k]});
    parity_clear_i <= 1'b0;
    for (int k = 0; k < 4; k++)
      xfer(3 - k, 1'b0, tab[k], 24'h0);
    $display("test module done");
    stop_on_parity_i <= 1'b1;
    for (int k = 0; k < 4; k++)
      put(k, 1'b1, 15'h0200 + 15'(k), {seed, 8'(k)});
    @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      wait_done(k);
      chk("order", (24'h1 << (k + 1)) - 24'h1, {20'h0, done});
    end
    for (int k = 0; k < 4; k++)
      xfer(k, 1'b0, 15'h0200 + 15'(k), 24'h0);
    $display("test priority done");
    temp_alarm_i <= 1'b1;
    put(3, 1'b0, tab[0], 24'h0);
    repeat (120) @(posedge clk_i);
    chk("held", 24'h0, {23'h0, done[3]});
    temp_alarm_i <= 1'b0;
    wait_done(3);
    chk("rdata", exp_w[3], m.rd_reg[3]);
    $display("test alarm done");
    complete_run();
  end
endmodule : core_memory_access_control_bench

bind cmac_ctrl cmac_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
  .grant_o(grant_o), .data_ready_o(data_ready_o), .au_release_o(au_release_o),
  .init_lower_o(init_lower_o), .init_upper_o(init_upper_o), .op_write_o(op_write_o),
  .op_read_o(op_read_o), .parity_err_o(parity_err_o), .parity_ok_test_o(parity_ok_test_o));
